// File: logic/pin_sharing.sv
/*
 * Pin sharing for port M pins 3..7 and the sixteen analog-digital pins,
 * with keypad wake-up flags and interrupt.
 * Assumes pins are resolved by the surroundings from out/enable pairs and
 * that configuration inputs come from registers on CLK_I.
 */
// Function
// RULE_01: Two-wire enable gives pin 7 clock
// RULE_02: Two-wire enable gives pin 6 data
// RULE_03: Transmitter enable makes pin 5 transmit
// RULE_04: Receiver enable makes pin 4 receive
// RULE_05: Reset leaves pins 3-7 undriven inputs
// RULE_06: Pin 3 is always plain I/O
// RULE_07: Analog pins feed converter, optional digital
// RULE_08: Digital analog pins may wake processor
// RULE_09: Read gives pin if input, else latch
// RULE_10: Peripheral ownership overrides direction bit
// RULE_11: Interrupt needs flag and enable together
// RULE_12: Disabled peripheral returns pin to I/O
// RULE_13: Wake enable ignored unless digital enabled
`timescale 1ns/1ps
`default_nettype none

module pin_sharing (
	// Clock and reset
	input  wire logic                        CLK_I,
	input  wire logic                        NRST_I,
	// Port M pins 3..7 (bit 0 is pin 3)
	input  wire logic [4:0]                  PORTM_PIN_I,
	output logic      [4:0]                  PORTM_PIN_O,
	output logic      [4:0]                  PORTM_PIN_OE_N_O,
	// Analog-digital pins
	input  wire logic [15:0]                 ANADIG_PIN_I,
	output logic      [15:0]                 ANADIG_PIN_O,
	output logic      [15:0]                 ANADIG_PIN_OE_N_O,
	// Port configuration
	input  wire pinshare_pkg::portm_cfg_type  PORTM_CFG_I,
	input  wire pinshare_pkg::anadig_cfg_type ANADIG_CFG_I,
	// Peripheral side
	input  wire pinshare_pkg::periph_req_type PERIPH_I,
	output logic                             TWO_WIRE_SCL_O,
	output logic                             TWO_WIRE_SDA_O,
	output logic                             SERIAL_RX_O,
	output logic      [15:0]                 CONVERTER_ANALOG_INPUT_O,
	// Port read-back
	output logic      [4:0]                  PORTM_READ_O,
	output logic      [15:0]                 ANADIG_READ_O,
	// Wake-up flags and interrupt
	input  wire logic [15:0]                 WAKE_FLAG_CLR_I,
	output logic      [15:0]                 WAKE_FLAG_O,
	output logic                             KEYPAD_WAKEUP_O
);

	logic [4:0]  pm_s1_q;
	logic [4:0]  pm_s2_q;
	logic [15:0] ad_s1_q;
	logic [15:0] ad_s2_q;
	logic [4:0]  pm_out_d;
	logic [4:0]  pm_oe_n_d;
	logic [4:0]  pm_out_q;
	logic [4:0]  pm_oe_n_q;
	logic [15:0] ad_out_q;
	logic [15:0] ad_oe_n_q;
	logic [15:0] edge_w;
	logic [15:0] flag_q;
	logic        irq_q;
	logic [4:0]  pm_periph_own;

	// ============================================================
	// Input synchronisers
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pm_s1_q <= pinshare_pkg::PM_RST;
			pm_s2_q <= pinshare_pkg::PM_RST;
			ad_s1_q <= pinshare_pkg::AD_RST;
			ad_s2_q <= pinshare_pkg::AD_RST;
		end else begin
			pm_s1_q <= PORTM_PIN_I;
			pm_s2_q <= pm_s1_q;
			ad_s1_q <= ANADIG_PIN_I;
			ad_s2_q <= ad_s1_q;
		end
	end

	// ============================================================
	// Port M ownership
	always_comb begin
		pm_periph_own = 5'h00;
		pm_periph_own[pinshare_pkg::PM_BIT_P7] = PERIPH_I.two_wire_en; // RULE_01
		pm_periph_own[pinshare_pkg::PM_BIT_P6] = PERIPH_I.two_wire_en; // RULE_02
		pm_periph_own[pinshare_pkg::PM_BIT_P5] = PERIPH_I.serial_tx_en; // RULE_03
		pm_periph_own[pinshare_pkg::PM_BIT_P4] = PERIPH_I.serial_rx_en; // RULE_04
	end

	always_comb begin
		// General-purpose default; peripherals override below
		pm_out_d  = PORTM_CFG_I.data; // RULE_06 RULE_12
		pm_oe_n_d = ~PORTM_CFG_I.dir;
		if (PERIPH_I.two_wire_en) begin
			pm_out_d[pinshare_pkg::PM_BIT_P7]  = PERIPH_I.two_wire_scl_o; // RULE_01
			pm_oe_n_d[pinshare_pkg::PM_BIT_P7] = PERIPH_I.two_wire_scl_oe_n; // RULE_10
			pm_out_d[pinshare_pkg::PM_BIT_P6]  = PERIPH_I.two_wire_sda_o; // RULE_02
			pm_oe_n_d[pinshare_pkg::PM_BIT_P6] = PERIPH_I.two_wire_sda_oe_n; // RULE_10
		end
		if (PERIPH_I.serial_tx_en) begin
			pm_out_d[pinshare_pkg::PM_BIT_P5]  = PERIPH_I.serial_tx; // RULE_03
			pm_oe_n_d[pinshare_pkg::PM_BIT_P5] = 1'b0;
		end
		if (PERIPH_I.serial_rx_en) begin
			// Receive pin is input only, whatever the direction bit says
			pm_out_d[pinshare_pkg::PM_BIT_P4]  = 1'b0; // RULE_04
			pm_oe_n_d[pinshare_pkg::PM_BIT_P4] = 1'b1; // RULE_10
		end
	end

	// Registered pin drive; reset leaves every pin undriven
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pm_out_q  <= pinshare_pkg::PM_RST;
			pm_oe_n_q <= pinshare_pkg::PM_OE_N_RST; // RULE_05
		end else begin
			pm_out_q  <= pm_out_d;
			pm_oe_n_q <= pm_oe_n_d;
		end
	end

	assign PORTM_PIN_O      = pm_out_q;
	assign PORTM_PIN_OE_N_O = pm_oe_n_q;

	// Peripheral inputs see the synchronised pin only while they own it
	assign TWO_WIRE_SCL_O = pm_periph_own[pinshare_pkg::PM_BIT_P7]
	                      ? pm_s2_q[pinshare_pkg::PM_BIT_P7] : 1'b1; // RULE_01 RULE_12
	assign TWO_WIRE_SDA_O = pm_periph_own[pinshare_pkg::PM_BIT_P6]
	                      ? pm_s2_q[pinshare_pkg::PM_BIT_P6] : 1'b1; // RULE_02 RULE_12
	assign SERIAL_RX_O    = pm_periph_own[pinshare_pkg::PM_BIT_P4]
	                      ? pm_s2_q[pinshare_pkg::PM_BIT_P4] : 1'b1; // RULE_04 RULE_12

	// Read-back mirrors the direction register, even under a peripheral
	assign PORTM_READ_O = (pm_s2_q & ~PORTM_CFG_I.dir)
	                    | (PORTM_CFG_I.data & PORTM_CFG_I.dir); // RULE_09

	// ============================================================
	// Analog-digital port
	// The converter always sees the raw pin; the digital buffer is optional
	assign CONVERTER_ANALOG_INPUT_O = ANADIG_PIN_I; // RULE_07

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ad_out_q  <= pinshare_pkg::AD_RST;
			ad_oe_n_q <= ~pinshare_pkg::AD_RST;
		end else begin
			ad_out_q  <= ANADIG_CFG_I.data;
			ad_oe_n_q <= ~ANADIG_CFG_I.dir; // RULE_07
		end
	end

	assign ANADIG_PIN_O      = ad_out_q;
	assign ANADIG_PIN_OE_N_O = ad_oe_n_q;

	// Input buffer disabled reads zero, saving power on analog pins
	assign ANADIG_READ_O = (ad_s2_q & ANADIG_CFG_I.dig_en & ~ANADIG_CFG_I.dir)
	                     | (ANADIG_CFG_I.data & ANADIG_CFG_I.dir); // RULE_09

	// ============================================================
	// Wake-up filters, one per pin
	genvar gi;
	generate
		for (gi = 0; gi < pinshare_pkg::AD_WIDTH; gi++) begin : g_wake
			wake_filter u_filt (
				.CLK_I   (CLK_I),
				.NRST_I  (NRST_I),
				.level_i (ad_s2_q[gi]),
				.rise_i  (ANADIG_CFG_I.rise_sel[gi]),
				.edge_o  (edge_w[gi])
			);
		end
	endgenerate

	// Sticky flags; a new edge wins over a clear in the same cycle
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			flag_q <= pinshare_pkg::AD_RST;
		end else begin
			flag_q <= (flag_q & ~WAKE_FLAG_CLR_I) | (edge_w & ANADIG_CFG_I.dig_en); // RULE_08
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(flag_q & ANADIG_CFG_I.wake_en & ANADIG_CFG_I.dig_en); // RULE_11 RULE_13
		end
	end

	assign WAKE_FLAG_O     = flag_q;
	assign KEYPAD_WAKEUP_O = irq_q;

	// ============================================================
	// Assertions
	sequence s_twi_on;
		PERIPH_I.two_wire_en && !PERIPH_I.two_wire_scl_oe_n;
	endsequence

	a_scl_handover: assert property (@(posedge CLK_I) disable iff (!NRST_I) // RULE_01
		s_twi_on |=> !PORTM_PIN_OE_N_O[4] && PORTM_PIN_O[4] == $past(PERIPH_I.two_wire_scl_o))
		else $error("pin 7 not handed to two-wire clock");
	a_sda_handover: assert property (@(posedge CLK_I) disable iff (!NRST_I) // RULE_02
		PERIPH_I.two_wire_en |=> PORTM_PIN_OE_N_O[3] == $past(PERIPH_I.two_wire_sda_oe_n))
		else $error("pin 6 not handed to two-wire data");
	a_tx_drive: assert property (@(posedge CLK_I) disable iff (!NRST_I) // RULE_03
		PERIPH_I.serial_tx_en |=> !PORTM_PIN_OE_N_O[2] && PORTM_PIN_O[2] == $past(PERIPH_I.serial_tx))
		else $error("pin 5 not driven by transmitter");
	a_rx_input: assert property (@(posedge CLK_I) disable iff (!NRST_I) // RULE_04 RULE_10
		PERIPH_I.serial_rx_en |=> PORTM_PIN_OE_N_O[1])
		else $error("pin 4 driven while receiving");
	a_reset_hiz: assert property (@(posedge CLK_I) // RULE_05
		!NRST_I |-> PORTM_PIN_OE_N_O == 5'h1F)
		else $error("port M driven during reset");
	a_pin3_gpio: assert property (@(posedge CLK_I) disable iff (!NRST_I) // RULE_06
		1'b1 |=> PORTM_PIN_OE_N_O[0] == !$past(PORTM_CFG_I.dir[0]))
		else $error("pin 3 not following direction");
	a_release_gpio: assert property (@(posedge CLK_I) disable iff (!NRST_I) // RULE_12
		$fell(PERIPH_I.two_wire_en) |=> PORTM_PIN_OE_N_O[4] == !$past(PORTM_CFG_I.dir[4]))
		else $error("pin 7 not returned to I/O");
	a_read_out: assert property (@(posedge CLK_I) disable iff (!NRST_I) // RULE_09
		PORTM_CFG_I.dir[0] |-> PORTM_READ_O[0] == PORTM_CFG_I.data[0])
		else $error("read of output bit wrong");
	a_irq_cause: assert property (@(posedge CLK_I) disable iff (!NRST_I) // RULE_11 RULE_13
		KEYPAD_WAKEUP_O == $past(|(WAKE_FLAG_O & ANADIG_CFG_I.wake_en & ANADIG_CFG_I.dig_en)))
		else $error("wake-up not matching enabled flags");
	a_flag_digital: assert property (@(posedge CLK_I) disable iff (!NRST_I) // RULE_08
		$rose(flag_q[0]) |-> $past(ANADIG_CFG_I.dig_en[0]))
		else $error("flag set on analog-only pin");

endmodule : pin_sharing

`default_nettype wire

// File: logic/pinshare_pkg.sv
/*
 * Package for the port M / analog-digital pin sharing block: widths, reset
 * values, filter timing and carrier structs.
 * Assumes a single 10 MHz bus clock and active-low asynchronous reset.
 */
`default_nettype none

package pinshare_pkg;

	// ============================================================
	// Widths and reset values
	localparam int          AD_WIDTH     = 16;
	localparam int          PM_WIDTH     = 5;
	localparam logic [15:0] AD_RST       = 16'h0000;
	localparam logic [4:0]  PM_RST       = 5'h00;
	localparam logic [4:0]  PM_OE_N_RST  = 5'h1F;

	// ============================================================
	// Port M bit positions (bit 0 of the group is pin 3)
	localparam int PM_BIT_P3 = 0;
	localparam int PM_BIT_P4 = 1;
	localparam int PM_BIT_P5 = 2;
	localparam int PM_BIT_P6 = 3;
	localparam int PM_BIT_P7 = 4;

	// ============================================================
	// Wake-up glitch filter: pulses of this many bus clocks are valid
	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          FILT_VALID_CLKS = 4;
	localparam logic [2:0]  FILT_CNT_MAX    = 3'(FILT_VALID_CLKS - 1);

	// ============================================================
	// Carriers
	typedef struct packed {
		logic [4:0] data;
		logic [4:0] dir;
	} portm_cfg_type;

	typedef struct packed {
		logic [15:0] data;
		logic [15:0] dir;
		logic [15:0] dig_en;
		logic [15:0] wake_en;
		logic [15:0] rise_sel;
	} anadig_cfg_type;

	typedef struct packed {
		logic two_wire_en;
		logic two_wire_scl_o;
		logic two_wire_scl_oe_n;
		logic two_wire_sda_o;
		logic two_wire_sda_oe_n;
		logic serial_tx_en;
		logic serial_tx;
		logic serial_rx_en;
	} periph_req_type;

endpackage : pinshare_pkg

`default_nettype wire

// File: logic/wake_filter.sv
/*
 * One wake-up pin: glitch filter and edge detect on an already
 * synchronised level. Assumes the input passed two flip-flops upstream.
 */
`timescale 1ns/1ps
`default_nettype none

module wake_filter (
	// Clock and reset
	input  wire logic CLK_I,
	input  wire logic NRST_I,
	// Level and polarity
	input  wire logic level_i,
	input  wire logic rise_i,
	// Qualified edge
	output logic      edge_o
);

	logic [2:0] cnt_q;
	logic       stable_q;

	// ============================================================
	// Filter: a level must hold FILT_VALID_CLKS clocks to be accepted, or only one clock if it reverses a change accepted on the clock before
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			cnt_q <= 3'h0;
		end else if (level_i == stable_q) begin
			cnt_q <= 3'h0;
		end else if (cnt_q != pinshare_pkg::FILT_CNT_MAX) begin
			cnt_q <= cnt_q + 3'h1;
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			stable_q <= 1'b0;
		end else if (level_i != stable_q && cnt_q == pinshare_pkg::FILT_CNT_MAX) begin
			stable_q <= level_i;
		end
	end

	assign edge_o = (level_i != stable_q) && (cnt_q == pinshare_pkg::FILT_CNT_MAX)
	                && (level_i == rise_i);

endmodule : wake_filter

`default_nettype wire

// File: testbench/pin_board.sv
/*
 * Board-side model of a group of shared pins: resolves the wire from the
 * design's drive and an external driver. Assumes one bus clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_board #(
	parameter int W = 5
) (
	input  wire logic         clk_i,
	input  wire logic [W-1:0] out_i,
	input  wire logic [W-1:0] oe_n_i,
	input  wire logic [W-1:0] ext_val_i,
	input  wire logic [W-1:0] ext_en_i,
	output logic      [W-1:0] level_o
);
	// ============================================================
	// Wire resolution
	logic [W-1:0] last_q = '0;

	// An undriven pin toggles every cycle so a stale value is never read as valid
	always_comb begin
		for (int b = 0; b < W; b++) begin
			if (!oe_n_i[b])
				level_o[b] = out_i[b];
			else if (ext_en_i[b])
				level_o[b] = ext_val_i[b];
			else
				level_o[b] = ~last_q[b];
		end
	end

	always_ff @(posedge clk_i) begin
		last_q <= level_o;
	end
endmodule : pin_board

`default_nettype wire

// File: testbench/tb_top.sv
/*
 * Self-checking bench for the pin sharing block.
 * Assumes inputs change on the falling clock edge only.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// ============================================================
	// Signals
	logic                          clk = 1'b0;
	logic                          nrst_n = 1'b1;
	logic [4:0]                    pm_lvl, pm_o, pm_oe_n, pm_ext, pm_ext_en, pm_rd;
	logic [15:0]                   ad_lvl, ad_o, ad_oe_n, ad_ext, ad_rd, conv, flg, clr;
	logic                          scl, sda, rx, keypad_wakeup;
	pinshare_pkg::portm_cfg_type   pm_cfg;
	pinshare_pkg::anadig_cfg_type  ad_cfg;
	pinshare_pkg::periph_req_type  per;
	int                            failures = 0;
	int                            cmp_count = 0;

	always #50 clk = ~clk;

	pin_sharing uut (.CLK_I(clk), .NRST_I(nrst_n), .PORTM_PIN_I(pm_lvl), .PORTM_PIN_O(pm_o),
		.PORTM_PIN_OE_N_O(pm_oe_n), .ANADIG_PIN_I(ad_lvl), .ANADIG_PIN_O(ad_o),
		.ANADIG_PIN_OE_N_O(ad_oe_n), .PORTM_CFG_I(pm_cfg), .ANADIG_CFG_I(ad_cfg),
		.PERIPH_I(per), .TWO_WIRE_SCL_O(scl), .TWO_WIRE_SDA_O(sda), .SERIAL_RX_O(rx),
		.CONVERTER_ANALOG_INPUT_O(conv), .PORTM_READ_O(pm_rd), .ANADIG_READ_O(ad_rd),
		.WAKE_FLAG_CLR_I(clr), .WAKE_FLAG_O(flg), .KEYPAD_WAKEUP_O(keypad_wakeup));
	pin_board #(.W(5)) pm_brd (.clk_i(clk), .out_i(pm_o), .oe_n_i(pm_oe_n),
		.ext_val_i(pm_ext), .ext_en_i(pm_ext_en), .level_o(pm_lvl));
	pin_board #(.W(16)) ad_brd (.clk_i(clk), .out_i(ad_o), .oe_n_i(ad_oe_n),
		.ext_val_i(ad_ext), .ext_en_i(16'hFFFF), .level_o(ad_lvl));

	// ============================================================
	// Tasks
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask : step

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic pulse(input int bit_no, input int len);
		ad_ext[bit_no] = 1'b1;
		step(len);
		ad_ext[bit_no] = 1'b0;
		step(12);
	endtask : pulse

	task automatic end_sim;
		$display("failures=%0d cmp_count=%0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// ============================================================
	// Watchdog: the tests need well under 300 cycles
	initial begin
		#(100 * 2000);
		failures++;
		end_sim();
	end

	// ============================================================
	// Tests
	initial begin
		// Non-blocking, so the reset edge reaches processes already waiting on it
		nrst_n <= 1'b0;
		pm_cfg = '0;
		ad_cfg = '0;
		per = '0;
		clr = 16'h0000;
		ad_ext = 16'h0000;
		pm_ext = 5'h00;
		pm_ext_en = 5'h00;
		step(8);
		chk(pm_oe_n, 5'h1F);
		step(8);
		nrst_n = 1'b1;
		step(1);
		chk(pm_oe_n, 5'h1F);
		pm_cfg.dir = 5'h1F;
		pm_cfg.data = 5'h15;
		step(2);
		chk(pm_oe_n, 5'h00);
		chk(pm_o, 5'h15);
		chk(pm_rd, 5'h15);
		// Owners take pins 7..4 while every direction bit asks for output
		per = '{two_wire_en: 1'b1, two_wire_scl_o: 1'b1, two_wire_scl_oe_n: 1'b0,
			two_wire_sda_o: 1'b0, two_wire_sda_oe_n: 1'b1, serial_tx_en: 1'b1,
			serial_tx: 1'b0, serial_rx_en: 1'b1};
		pm_ext_en = 5'h0A;
		pm_ext = 5'h00;
		step(3);
		chk(pm_oe_n, 5'h0A);
		chk({pm_o[4], pm_o[2], pm_o[0]}, 3'h5);
		chk({scl, sda}, 2'h2);
		chk(rx, 1'b0);
		pm_ext = 5'h0A;
		step(3);
		chk({sda, rx}, 2'h3);
		per.serial_tx = 1'b1;
		step(2);
		chk(pm_o[2], 1'b1);
		per = '0;
		pm_cfg.dir = 5'h00;
		pm_ext_en = 5'h1F;
		pm_ext = 5'h12;
		step(3);
		chk(pm_oe_n, 5'h1F);
		chk(pm_rd, 5'h12);
		chk({scl, sda, rx}, 3'h7);
		// Analog-digital pins: converter feed, read-back and wake-up
		ad_cfg.dig_en = 16'h0003;
		ad_cfg.wake_en = 16'h0005;
		ad_cfg.rise_sel = 16'h0007;
		ad_ext = 16'h8002;
		step(3);
		chk(conv, 16'h8002);
		chk(ad_rd, 16'h0002);
		chk(ad_oe_n, 16'hFFFF);
		ad_ext = 16'h0000;
		step(12);
		clr = 16'hFFFF;
		step(1);
		clr = 16'h0000;
		step(2);
		chk(flg, 16'h0000);
		pulse(0, 2);
		chk(flg, 16'h0000);
		pulse(1, 8);
		chk({flg, keypad_wakeup}, 17'h00004);
		pulse(2, 8);
		chk({flg, keypad_wakeup}, 17'h00004);
		pulse(0, 8);
		chk({flg, keypad_wakeup}, 17'h00007);
		clr = 16'h0001;
		step(1);
		clr = 16'h0000;
		step(2);
		chk({flg, keypad_wakeup}, 17'h00004);
		ad_cfg.dir = 16'h00F0;
		ad_cfg.data = 16'h0050;
		step(2);
		chk({ad_oe_n, ad_o[7:4]}, 20'hFF0F5);
		chk(ad_rd, 16'h0050);
		// Pin 3 set for falling edges: the rise is ignored, the fall flags
		ad_cfg.dig_en = 16'h000B;
		ad_cfg.wake_en = 16'h000D;
		pulse(3, 8);
		chk({flg, keypad_wakeup}, 17'h00015);
		end_sim();
	end
endmodule : tb_top

`default_nettype wire
